/* File: src/acifs_pkg.sv */
// Purpose: Shared constants for the processor audio input FIFO block
// Assumes: Wishbone byte addresses, 32-bit data
// Notes:   Data windows repeat over four words each
package acifs_pkg;
   localparam int          DEPTH        = 6;
   localparam int          SAMPLE_W     = 20;
   localparam int          NUM_SRC      = 8;
   localparam logic [7:0]  CTRL_OFS     = 8'h30;
   localparam logic [7:0]  ONE_L_OFS    = 8'h34;
   localparam logic [7:0]  THREE_L_OFS  = 8'h44;
   localparam logic [7:0]  ONE_R_OFS    = 8'h54;
   localparam logic [7:0]  THREE_R_OFS  = 8'h64;
   localparam logic [7:0]  STEREO_OFS   = 8'h74;
   localparam logic [7:0]  WIN_SPAN     = 8'h10;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   // Control field positions
   localparam int          THR_ONE_LSB  = 6;
   localparam int          THR_TWO_LSB  = 14;
   localparam int          THR_THR_LSB  = 20;
   localparam int          SEL_THR_LSB  = 16;
   localparam int          SEL_TWO_MSB  = 13;
   localparam int          SEL_TWO_LSB  = 3;
   localparam int          SEL_ONE_MSB  = 12;
   localparam int          SEL_ONE_LSB  = 0;
   localparam int          ZERO_THR_BIT = 23;
   localparam int          ZERO_TWO_BIT = 11;
   localparam int          ZERO_ONE_BIT = 10;
   localparam int          KEEP_THR_BIT = 22;
   localparam int          KEEP_TWO_BIT = 9;
   localparam int          KEEP_ONE_BIT = 8;
   // Source select codes
   localparam logic [3:0]  SRC_OFF      = 4'h0;
   localparam logic [3:0]  SRC_UNUSED   = 4'h3;
   localparam logic [3:0]  SRC_LAST     = 4'h8;
   // Source resolution codes
   localparam logic [1:0]  RES_20       = 2'h0;
   localparam logic [1:0]  RES_18       = 2'h1;
   localparam logic [1:0]  RES_16       = 2'h2;
   // Threshold codes
   localparam logic [1:0]  THR_1        = 2'h0;
   localparam logic [1:0]  THR_2        = 2'h1;
   localparam logic [1:0]  THR_3        = 2'h2;
   localparam logic [2:0]  LVL_1        = 3'h1;
   localparam logic [2:0]  LVL_2        = 3'h2;
   localparam logic [2:0]  LVL_3        = 3'h3;
   localparam logic [2:0]  LVL_6        = 3'h6;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } acifs_bus_t;
   typedef enum logic [2:0] {
      TGT_NONE, TGT_CTRL, TGT_ONE_L, TGT_ONE_R, TGT_THR_L, TGT_THR_R, TGT_TWO
   } acifs_tgt_t;
endpackage : acifs_pkg

/* File: src/acifs_fifo.sv */
// Purpose: Single-channel sample FIFO built from flip-flops
// Assumes: Push while full and pop while empty are dropped
// Notes:   Keep-one holds the oldest entry and blocks further pushes
`timescale 1ns/1ps
`default_nettype none
module acifs_fifo #(
   parameter int W     = 20,
   parameter int DEPTH = 6,
   parameter int LW    = 3
) (
   input  wire logic          mclk_in,
   input  wire logic          srst_in,
   input  wire logic          push_in,
   input  wire logic [W-1:0]  data_in,
   input  wire logic          pop_in,
   input  wire logic          keep_one_in,
   output logic      [W-1:0]  head_out,
   output logic      [LW-1:0] level_out
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0]  mem_q [DEPTH];
   logic [W-1:0]  mem_d [DEPTH];
   logic [PW-1:0] rd_q, rd_d, wr_q, wr_d;
   logic [LW-1:0] cnt_q, cnt_d;
   logic          do_push, do_pop;

   function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
      inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction : inc

   always_comb begin
      mem_d   = mem_q;
      rd_d    = rd_q;
      wr_d    = wr_q;
      cnt_d   = cnt_q;
      do_push = push_in && (cnt_q != LW'(DEPTH));
      do_pop  = pop_in && (cnt_q != '0);
      if (keep_one_in) begin
         // Oldest entry survives; the next write lands right behind it
         if (cnt_q != '0) begin
            cnt_d = LW'(1);
            wr_d  = inc(rd_q);
         end else if (push_in) begin
            mem_d[wr_q] = data_in;
            wr_d        = inc(wr_q);
            cnt_d       = LW'(1);
         end
      end else begin
         if (do_push) begin
            mem_d[wr_q] = data_in;
            wr_d        = inc(wr_q);
         end
         if (do_pop) begin
            rd_d = inc(rd_q);
         end
         cnt_d = cnt_q + LW'(do_push) - LW'(do_pop);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         rd_q  <= '0;
         wr_q  <= '0;
         cnt_q <= '0;
      end else begin
         rd_q  <= rd_d;
         wr_q  <= wr_d;
         cnt_q <= cnt_d;
      end
      mem_q <= mem_d;
   end

   assign head_out  = mem_q[rd_q];
   assign level_out = cnt_q;
endmodule : acifs_fifo
`default_nettype wire

/* File: src/acifs_top.sv */
// Purpose: Processor audio input FIFOs with source select and control register
// Assumes: Classic Wishbone slave, one clock, synchronous reset
// Notes:   Each data read pops one sample unless keep-one is set; full flags double as DMA requests
`timescale 1ns/1ps
`default_nettype none
module acifs_top #(
   parameter int DEPTH = acifs_pkg::DEPTH,
   parameter int NSRC  = acifs_pkg::NUM_SRC
) (
   input  wire logic                                mclk_in,
   input  wire logic                                srst_in,
   input  wire logic                                wb_cyc_in,
   input  wire logic                                wb_stb_in,
   input  wire logic                                wb_we_in,
   input  wire logic [7:0]                          wb_adr_in,
   input  wire logic [3:0]                          wb_sel_in,
   input  wire logic [31:0]                         wb_dat_in,
   output logic      [31:0]                         wb_dat_out,
   output logic                                     wb_ack_out,
   input  wire logic [NSRC-1:0]                     src_valid_in,
   input  wire logic [NSRC-1:0][acifs_pkg::SAMPLE_W-1:0] src_left_in,
   input  wire logic [NSRC-1:0][acifs_pkg::SAMPLE_W-1:0] src_right_in,
   input  wire logic [NSRC-1:0][1:0]                src_res_in,
   output logic      [2:0]                          fifo_full_out
);
   localparam int SW = acifs_pkg::SAMPLE_W;
   localparam int LW = $clog2(DEPTH + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers
   function automatic logic [1:0] thr_field(input logic [31:0] c, input int lsb);
      thr_field = c[lsb +: 2];
   endfunction : thr_field

   function automatic logic over_thr(input logic [LW-1:0] lvl, input logic [1:0] code);
      case (code)
         acifs_pkg::THR_1: over_thr = lvl >= LW'(acifs_pkg::LVL_1);
         acifs_pkg::THR_2: over_thr = lvl >= LW'(acifs_pkg::LVL_2);
         acifs_pkg::THR_3: over_thr = lvl >= LW'(acifs_pkg::LVL_3);
         default:          over_thr = lvl >= LW'(acifs_pkg::LVL_6);
      endcase
   endfunction : over_thr

   // Unused and out-of-range codes give no source
   function automatic logic src_on(input logic [3:0] code);
      src_on = (code != acifs_pkg::SRC_OFF) && (code != acifs_pkg::SRC_UNUSED)
               && (code <= acifs_pkg::SRC_LAST);
   endfunction : src_on

   // Code 1,2 map to slots 0,1; codes 4..8 map to slots 2..6
   function automatic logic [2:0] src_slot(input logic [3:0] code);
      src_slot = (code < acifs_pkg::SRC_UNUSED) ? 3'(code - 4'h1) : 3'(code - 4'h2);
   endfunction : src_slot

   // Mask the bits a short source never delivers
   function automatic logic [SW-1:0] align(input logic [SW-1:0] s, input logic [1:0] res);
      case (res)
         acifs_pkg::RES_18: align = {s[SW-1:2], 2'h0};
         acifs_pkg::RES_16: align = {s[SW-1:4], 4'h0};
         default:           align = s;
      endcase
   endfunction : align

   function automatic logic [31:0] pack_mono(input logic [SW-1:0] s);
      pack_mono = {~s[SW-1], s[SW-1], s[SW-1], s[SW-2:0], 10'h000};
   endfunction : pack_mono

   function automatic acifs_pkg::acifs_tgt_t decode(input logic [7:0] a);
      logic [7:0] w;
      w = {a[7:2], 2'h0};
      if (w == acifs_pkg::CTRL_OFS)
         decode = acifs_pkg::TGT_CTRL;
      else if (w >= acifs_pkg::ONE_L_OFS && w < acifs_pkg::THREE_L_OFS)
         decode = acifs_pkg::TGT_ONE_L;
      else if (w >= acifs_pkg::THREE_L_OFS && w < acifs_pkg::ONE_R_OFS)
         decode = acifs_pkg::TGT_THR_L;
      else if (w >= acifs_pkg::ONE_R_OFS && w < acifs_pkg::THREE_R_OFS)
         decode = acifs_pkg::TGT_ONE_R;
      else if (w >= acifs_pkg::THREE_R_OFS && w < acifs_pkg::STEREO_OFS)
         decode = acifs_pkg::TGT_THR_R;
      else if (w >= acifs_pkg::STEREO_OFS && w < 8'(acifs_pkg::STEREO_OFS + acifs_pkg::WIN_SPAN))
         decode = acifs_pkg::TGT_TWO;
      else
         decode = acifs_pkg::TGT_NONE;
   endfunction : decode

   ////////////////////////////////////////////////////////////////////////////
   // Control register and bus state
   acifs_pkg::acifs_bus_t state_q, state_d;
   acifs_pkg::acifs_tgt_t tgt;
   logic [31:0]           ctrl_q, ctrl_d;
   logic [31:0]           rdat_q, rdat_d;
   logic                  ack_q, ack_d;
   logic [2:0]            full_q, full_d;
   logic                  take;

   logic [3:0] sel [3];
   logic [1:0] thr [3];
   logic [2:0] zero, keep;
   always_comb begin
      sel[0]  = {ctrl_q[acifs_pkg::SEL_ONE_MSB], ctrl_q[acifs_pkg::SEL_ONE_LSB +: 3]};
      sel[1]  = {ctrl_q[acifs_pkg::SEL_TWO_MSB], ctrl_q[acifs_pkg::SEL_TWO_LSB +: 3]};
      sel[2]  = ctrl_q[acifs_pkg::SEL_THR_LSB +: 4];
      thr[0]  = thr_field(ctrl_q, acifs_pkg::THR_ONE_LSB);
      thr[1]  = thr_field(ctrl_q, acifs_pkg::THR_TWO_LSB);
      thr[2]  = thr_field(ctrl_q, acifs_pkg::THR_THR_LSB);
      zero    = {ctrl_q[acifs_pkg::ZERO_THR_BIT], ctrl_q[acifs_pkg::ZERO_TWO_BIT],
                 ctrl_q[acifs_pkg::ZERO_ONE_BIT]};
      keep    = {ctrl_q[acifs_pkg::KEEP_THR_BIT], ctrl_q[acifs_pkg::KEEP_TWO_BIT],
                 ctrl_q[acifs_pkg::KEEP_ONE_BIT]};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source multiplexers and FIFOs
   logic [2:0]    push;
   logic [SW-1:0] in_l [3];
   logic [SW-1:0] in_r [3];
   logic [SW-1:0] head_l [3];
   logic [SW-1:0] head_r [3];
   logic [LW-1:0] lvl_l [3];
   logic [LW-1:0] lvl_r [3];
   logic [2:0]    pop_l, pop_r;
   logic [31:0]   head_two;
   logic [LW-1:0] lvl_two;
   logic          pop_two;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_path
         logic [2:0] slot;
         assign slot = src_slot(sel[g]);
         assign push[g] = src_on(sel[g]) && src_valid_in[slot];
         assign in_l[g] = align(src_left_in[slot], src_res_in[slot]);
         assign in_r[g] = align(src_right_in[slot], src_res_in[slot]);
         if (g != 1) begin : g_mono
            acifs_fifo #(.W(SW), .DEPTH(DEPTH), .LW(LW)) u_left (
               .mclk_in     (mclk_in),
               .srst_in     (srst_in),
               .push_in     (push[g]),
               .data_in     (in_l[g]),
               .pop_in      (pop_l[g]),
               .keep_one_in (keep[g]),
               .head_out    (head_l[g]),
               .level_out   (lvl_l[g])
            );
            acifs_fifo #(.W(SW), .DEPTH(DEPTH), .LW(LW)) u_right (
               .mclk_in     (mclk_in),
               .srst_in     (srst_in),
               .push_in     (push[g]),
               .data_in     (in_r[g]),
               .pop_in      (pop_r[g]),
               .keep_one_in (keep[g]),
               .head_out    (head_r[g]),
               .level_out   (lvl_r[g])
            );
         end else begin : g_stereo
            assign head_l[g] = '0;
            assign head_r[g] = '0;
            assign lvl_l[g]  = lvl_two;
            assign lvl_r[g]  = lvl_two;
         end
      end
   endgenerate

   // Stereo FIFO stores the packed word directly
   acifs_fifo #(.W(32), .DEPTH(DEPTH), .LW(LW)) u_stereo (
      .mclk_in     (mclk_in),
      .srst_in     (srst_in),
      .push_in     (push[1]),
      .data_in     ({in_l[1][SW-1 -: 16], in_r[1][SW-1 -: 16]}),
      .pop_in      (pop_two),
      .keep_one_in (keep[1]),
      .head_out    (head_two),
      .level_out   (lvl_two)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: answer one cycle after the request is taken
   assign take = wb_cyc_in && wb_stb_in && (state_q == acifs_pkg::BUS_IDLE);
   assign tgt  = decode(wb_adr_in);

   always_comb begin
      state_d = state_q;
      ctrl_d  = ctrl_q;
      rdat_d  = rdat_q;
      ack_d   = 1'b0;
      pop_l   = '0;
      pop_r   = '0;
      pop_two = 1'b0;
      case (state_q)
         acifs_pkg::BUS_IDLE: begin
            if (take) begin
               state_d = acifs_pkg::BUS_ACK;
               ack_d   = 1'b1;
               rdat_d  = '0;
               if (wb_we_in) begin
                  // Writes to data windows are accepted and dropped
                  if (tgt == acifs_pkg::TGT_CTRL) begin
                     for (int b = 0; b < 4; b++) begin
                        if (wb_sel_in[b]) begin
                           ctrl_d[8*b +: 8] = wb_dat_in[8*b +: 8];
                        end
                     end
                  end
               end else begin
                  // Each data window read pops; zero mode still drains the sample
                  case (tgt)
                     acifs_pkg::TGT_CTRL: rdat_d = ctrl_q;
                     acifs_pkg::TGT_ONE_L: begin
                        pop_l[0] = 1'b1;
                        rdat_d   = zero[0] ? '0 : pack_mono(head_l[0]);
                     end
                     acifs_pkg::TGT_ONE_R: begin
                        pop_r[0] = 1'b1;
                        rdat_d   = zero[0] ? '0 : pack_mono(head_r[0]);
                     end
                     acifs_pkg::TGT_THR_L: begin
                        pop_l[2] = 1'b1;
                        rdat_d   = zero[2] ? '0 : pack_mono(head_l[2]);
                     end
                     acifs_pkg::TGT_THR_R: begin
                        pop_r[2] = 1'b1;
                        rdat_d   = zero[2] ? '0 : pack_mono(head_r[2]);
                     end
                     acifs_pkg::TGT_TWO: begin
                        // Reader is expected to drain on flag only
                        pop_two = 1'b1;
                        rdat_d  = zero[1] ? '0 : head_two;
                     end
                     default: rdat_d = '0;
                  endcase
               end
            end
         end
         acifs_pkg::BUS_ACK: state_d = acifs_pkg::BUS_IDLE;
         default:             state_d = acifs_pkg::BUS_IDLE;
      endcase
   end

   // Full flags follow the left level against the threshold
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         full_d[i] = over_thr(lvl_l[i], thr[i]);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         state_q <= acifs_pkg::BUS_IDLE;
         // Everything off, thresholds at one sample
         ctrl_q  <= acifs_pkg::CTRL_RESET;
         rdat_q  <= '0;
         ack_q   <= 1'b0;
         full_q  <= '0;
      end else begin
         state_q <= state_d;
         ctrl_q  <= ctrl_d;
         rdat_q  <= rdat_d;
         ack_q   <= ack_d;
         full_q  <= full_d;
      end
   end

   assign wb_dat_out    = rdat_q;
   assign wb_ack_out    = ack_q;
   assign fifo_full_out = full_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_depth;
      @(posedge mclk_in) disable iff (srst_in)
      lvl_l[0] <= LW'(DEPTH) && lvl_l[2] <= LW'(DEPTH) && lvl_two <= LW'(DEPTH);
   endproperty
   a_depth: assert property (p_depth) else $error("FIFO level above depth");

   property p_full_six;
      @(posedge mclk_in) disable iff (srst_in)
      (thr[0] == 2'h3 && lvl_l[0] == LW'(5)) |=> !fifo_full_out[0];
   endproperty
   a_full_six: assert property (p_full_six) else $error("Threshold six flagged at five");

   property p_full_track;
      @(posedge mclk_in) disable iff (srst_in)
      fifo_full_out[2] == over_thr($past(lvl_l[2]), $past(thr[2]));
   endproperty
   a_full_track: assert property (p_full_track) else $error("Full flag out of step");

   property p_reset_ctrl;
      @(posedge mclk_in) disable iff (srst_in)
      $past(srst_in) |-> (ctrl_q == 32'h0000_0000 && fifo_full_out == 3'h0);
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl) else $error("Control not zero after reset");

   property p_zero_three;
      @(posedge mclk_in) disable iff (srst_in)
      (take && !wb_we_in && tgt == acifs_pkg::TGT_THR_L && zero[2]) |=> wb_ack_out && wb_dat_out == 32'h0;
   endproperty
   a_zero_three: assert property (p_zero_three) else $error("FIFO three zero mode leaked data");

   property p_zero_two;
      @(posedge mclk_in) disable iff (srst_in)
      (take && !wb_we_in && tgt == acifs_pkg::TGT_TWO && zero[1]) |=> wb_dat_out == 32'h0;
   endproperty
   a_zero_two: assert property (p_zero_two) else $error("Stereo zero mode leaked data");

   property p_zero_one;
      @(posedge mclk_in) disable iff (srst_in)
      (take && !wb_we_in && tgt == acifs_pkg::TGT_ONE_R && zero[0]) |=> wb_dat_out == 32'h0;
   endproperty
   a_zero_one: assert property (p_zero_one) else $error("FIFO one zero mode leaked data");

   property p_keep_three;
      @(posedge mclk_in) disable iff (srst_in)
      keep[2] |=> (lvl_l[2] <= LW'(1) && lvl_r[2] <= LW'(1));
   endproperty
   a_keep_three: assert property (p_keep_three) else $error("FIFO three kept more than one");

   property p_keep_two;
      @(posedge mclk_in) disable iff (srst_in)
      keep[1] ##1 keep[1] |-> lvl_two <= LW'(1);
   endproperty
   a_keep_two: assert property (p_keep_two) else $error("Stereo FIFO kept more than one");

   property p_keep_one;
      @(posedge mclk_in) disable iff (srst_in)
      (keep[0] && lvl_l[0] > LW'(1)) |=> lvl_l[0] == LW'(1);
   endproperty
   a_keep_one: assert property (p_keep_one) else $error("FIFO one not cut to one");

   property p_off_nopush;
      @(posedge mclk_in) disable iff (srst_in)
      !src_on(sel[2]) |-> !push[2];
   endproperty
   a_off_nopush: assert property (p_off_nopush) else $error("Push from an off source");

   property p_mono_fmt;
      @(posedge mclk_in) disable iff (srst_in)
      (take && !wb_we_in && tgt == acifs_pkg::TGT_ONE_L && !zero[0])
         |=> wb_dat_out[9:0] == 10'h000 && wb_dat_out[31] != wb_dat_out[30] && wb_dat_out[30] == wb_dat_out[29];
   endproperty
   a_mono_fmt: assert property (p_mono_fmt) else $error("Mono word layout broken");
endmodule : acifs_top
`default_nettype wire

/* File: tb/acifs_bus_master.sv */
// Purpose: Wishbone master standing in for the core or DMA reader
// Assumes: Slave acks once per request
// Notes:   Released lines show inverted values so stale data is not mistaken for valid data
`timescale 1ns/1ps
`default_nettype none
module acifs_bus_master (
   input  wire logic        mclk_in,
   input  wire logic        ack_in,
   input  wire logic [31:0] dat_in,
   output logic             cyc_out,
   output logic             we_out,
   output logic      [3:0]  sel_out,
   output logic      [7:0]  adr_out,
   output logic      [31:0] dat_out
);
   initial begin
      cyc_out = 1'b0;
      we_out  = 1'b0;
      sel_out = 4'h0;
      adr_out = 8'h00;
      dat_out = 32'h0000_0000;
   end
   // Held until ack is sampled; only the bench timeout ends a hang
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] q);
      @(posedge mclk_in);
      cyc_out <= 1'b1;
      we_out  <= w;
      sel_out <= s;
      adr_out <= a;
      dat_out <= d;
      do
         @(posedge mclk_in);
      while (ack_in !== 1'b1);
      q = dat_in;
      cyc_out <= 1'b0;
      we_out  <= ~w;
      sel_out <= ~s;
      adr_out <= ~a;
      dat_out <= ~d;
   endtask : xfer
endmodule : acifs_bus_master
`default_nettype wire

/* File: tb/audio_cpu_input_fifo_select_tb.sv */
// Purpose: Self-checking bench for the processor audio input FIFOs
// Assumes: Flags follow a level change within three cycles
// Notes:   FIFO one and three share model queues; all sources pulse together
`timescale 1ns/1ps
`default_nettype none
module audio_cpu_input_fifo_select_tb;
   logic             mclk_in = 1'b0;
   logic             srst_in = 1'b1;
   logic             cyc, we, ack;
   logic [7:0]       adr;
   logic [7:0]       vld = 8'h00;
   logic [31:0]      wdat, rdat, q, v, cv;
   logic [3:0]       sel, b;
   logic [7:0][19:0] sl = '0;
   logic [7:0][19:0] sr = '0;
   logic [7:0][1:0]  rs = '0;
   logic [2:0]       full;
   logic [31:0]      ql[$], qr[$], qs[$];
   logic [3:0]       sc = 4'h0;
   logic [1:0]       thr = 2'h0;
   logic             kp = 1'b0;
   int               seed = 26423;
   int               n_fail = 0;
   int               n_checks = 0;
   int               cyc_n = 0;
   always #2.5 mclk_in = ~mclk_in;
   acifs_top DUT (.mclk_in(mclk_in), .srst_in(srst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
      .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .src_valid_in(vld), .src_left_in(sl), .src_right_in(sr), .src_res_in(rs), .fifo_full_out(full));
   acifs_bus_master m (.mclk_in(mclk_in), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc), .we_out(we),
      .sel_out(sel), .adr_out(adr), .dat_out(wdat));
   ////////////////////////////////////////////////////////////////////////////
   function automatic int slot(input logic [3:0] c);
      if (c == 4'h1 || c == 4'h2)
         return int'(c) - 1;
      if (c >= 4'h4 && c <= 4'h8)
         return int'(c) - 2;
      return -1;
   endfunction : slot
   function automatic logic [19:0] msk(input logic [19:0] s, input logic [1:0] r);
      return (r == 2'h1) ? (s & 20'hffffc) : (r == 2'h2) ? (s & 20'hffff0) : s;
   endfunction : msk
   function automatic logic [31:0] mono(input logic [19:0] s);
      return {~s[19], s[19], s[19], s[18:0], 10'h000};
   endfunction : mono
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task automatic setc(input logic [3:0] c, input logic [1:0] t, input logic z, input logic k);
      m.xfer(1'b1, acifs_pkg::CTRL_OFS, {8'h00, z, k, t, c, t, c[3], c[3], z, z, k, k, t, c[2:0], c[2:0]},
             4'hf, q);
      sc = c;
      thr = t;
      kp = k;
   endtask : setc
   task automatic push();
      logic [7:0][19:0] nl, nr;
      logic [7:0][1:0]  nres;
      logic [19:0]      ml, mr;
      int               s;
      s = slot(sc);
      for (int i = 0; i < 8; i++) begin
         nl[i] = 20'($random(seed));
         nr[i] = 20'($random(seed));
         nres[i] = 2'($random(seed));
      end
      @(posedge mclk_in);
      sl <= nl;
      sr <= nr;
      rs <= nres;
      vld <= 8'hff;
      if (s >= 0 && ql.size() < (kp ? 1 : acifs_pkg::DEPTH)) begin
         ml = msk(nl[s], nres[s]);
         mr = msk(nr[s], nres[s]);
         ql.push_back(mono(ml));
         qr.push_back(mono(mr));
         qs.push_back({ml[19:4], mr[19:4]});
      end
      @(posedge mclk_in);
      vld <= 8'h00;
   endtask : push
   task automatic rdw(input logic [7:0] a, input logic [31:0] e, input logic z);
      m.xfer(1'b0, a + 8'(($random(seed) & 3) * 4), 32'h0, 4'hf, q);
      chk(q, z ? 32'h0 : e); // oldest or zero
   endtask : rdw
   task automatic rd_all(input logic z);
      logic [31:0] l, r;
      if (ql.size() > 0) begin
         l = ql.pop_front();
         r = qr.pop_front();
         rdw(acifs_pkg::ONE_L_OFS, l, z);
         rdw(acifs_pkg::THREE_L_OFS, l, z);
         rdw(acifs_pkg::ONE_R_OFS, r, z);
         rdw(acifs_pkg::THREE_R_OFS, r, z);
      end
      if (full[1] === 1'b1 && qs.size() > 0)
         rdw(acifs_pkg::STEREO_OFS, qs.pop_front(), z);
   endtask : rd_all
   task automatic cflag();
      int l;
      l = (thr == 2'h3) ? 6 : int'(thr) + 1;
      repeat (3) @(posedge mclk_in);
      chk({29'h0, full}, {29'h0, ql.size() >= l, qs.size() >= l, ql.size() >= l}); // levels
   endtask : cflag
   always @(posedge mclk_in) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         n_fail++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge mclk_in);
      srst_in <= 1'b0;
      m.xfer(1'b0, acifs_pkg::CTRL_OFS, 32'h0, 4'hf, q);
      chk(q, acifs_pkg::CTRL_RESET); // reset value
      m.xfer(1'b0, 8'hc0, 32'h0, 4'hf, q);
      chk(q, 32'h0); // unmapped reads zero
      for (int c = 0; c < 16; c++) begin
         setc(4'(c), 2'h0, 1'b0, 1'b0);
         push();
         cflag();
         rd_all(1'b0);
      end
      // Seventh push overflows and must be lost
      for (int t = 0; t < 4; t++) begin
         setc(4'h4, 2'(t), 1'b0, 1'b0);
         repeat (7) begin
            push();
            cflag();
         end
         setc(4'h4, 2'h0, 1'b0, 1'b0);
         repeat (6) rd_all(1'b0);
         cflag();
      end
      setc(4'h5, 2'h0, 1'b1, 1'b0);
      repeat (2) push();
      cflag();
      rd_all(1'b1);
      cflag();
      setc(4'h5, 2'h0, 1'b0, 1'b0);
      rd_all(1'b0);
      setc(4'h7, 2'h1, 1'b0, 1'b0);
      repeat (3) push();
      cflag();
      setc(4'h7, 2'h1, 1'b0, 1'b1);
      ql = ql[0:0];
      qr = qr[0:0];
      qs = qs[0:0];
      push();
      cflag();
      setc(4'h7, 2'h0, 1'b0, 1'b0);
      cflag();
      rd_all(1'b0);
      cflag();
      // Byte lanes merge into the last known value
      cv = 32'h0000_0000;
      m.xfer(1'b1, acifs_pkg::CTRL_OFS, cv, 4'hf, q);
      repeat (4) begin
         v = $random(seed) & 32'h00ff_ffff;
         b = 4'($random(seed));
         m.xfer(1'b1, acifs_pkg::CTRL_OFS, v, b, q);
         for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
               cv[8*i +: 8] = v[8*i +: 8];
            end
         end
         m.xfer(1'b0, acifs_pkg::CTRL_OFS, 32'h0, 4'hf, q);
         chk(q, cv); // control read back
      end
      conclude();
   end
endmodule : audio_cpu_input_fifo_select_tb
`default_nettype wire
